// ### sld_pkg.sv
package sld_pkg;

  localparam int unsigned SLD_NUM_PORTS = 6;
  localparam int unsigned SLD_AW = 36;

  // Configuration offsets
  localparam logic [7:0] SLD_OFS_CTRL = 8'h9D;
  localparam logic [7:0] SLD_OFS_LOCK = 8'h9E;
  localparam logic [7:0] SLD_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLD_RDATA_RESET = 8'h00;

  // Control field positions
  localparam int unsigned SLD_BIT_HIGH_SMRAM = 7;
  localparam int unsigned SLD_BIT_MONO_PRESENT = 6;
  localparam int unsigned SLD_BIT_APIC_REDIRECT = 5;
  localparam int unsigned SLD_BIT_COMP_DISABLE = 4;
  localparam int unsigned SLD_BIT_GLOBAL_SMM = 3;
  localparam int unsigned SLD_BIT_SEG_SIZE_HI = 2;
  localparam int unsigned SLD_BIT_SEG_SIZE_LO = 1;
  localparam int unsigned SLD_BIT_SEG_ENABLE = 0;
  localparam int unsigned SLD_BIT_LOCK = 4;
  // Bits that the lock freezes
  localparam logic [7:0] SLD_LOCKED_MASK = 8'h8F;

  // I/O decode, dword index of address bits 9:2
  localparam logic [7:0] SLD_DW_VGA_LO_A = 8'hEC;
  localparam logic [7:0] SLD_DW_VGA_HI_A = 8'hEE;
  localparam logic [7:0] SLD_DW_VGA_LO_B = 8'hF0;
  localparam logic [7:0] SLD_DW_VGA_HI_B = 8'hF7;
  localparam logic [7:0] SLD_DW_MONO_3B4 = 8'hED;
  localparam logic [7:0] SLD_DW_MONO_3B8 = 8'hEE;
  localparam logic [7:0] SLD_DW_MONO_3BC = 8'hEF;
  localparam logic [3:0] SLD_BE_MONO_3B4 = 4'h3;
  localparam logic [3:0] SLD_BE_MONO_3B8 = 4'h7;

  // Memory ranges
  localparam logic [35:0] SLD_MONO_MEM_LO = 36'h0_000B_0000;
  localparam logic [35:0] SLD_MONO_MEM_HI = 36'h0_000B_7FFF;
  localparam logic [35:0] SLD_VGA_MEM_LO = 36'h0_000A_0000;
  localparam logic [35:0] SLD_VGA_MEM_HI = 36'h0_000B_FFFF;
  localparam logic [35:0] SLD_COMPAT_LO = 36'h0_000A_0000;
  localparam logic [35:0] SLD_COMPAT_HI = 36'h0_000B_FFFF;
  localparam logic [35:0] SLD_APIC_SB_LO = 36'h0_FEC0_0000;
  localparam logic [35:0] SLD_APIC_SB_HI = 36'h0_FEC7_FFFF;
  localparam logic [35:0] SLD_APIC_PORT_LO = 36'h0_FEC8_0000;
  localparam logic [35:0] SLD_APIC_PORT_HI = 36'h0_FEC8_5FFF;
  localparam int unsigned SLD_APIC_WIN_LSB = 12;
  localparam logic [35:0] SLD_SEG_LEN_MIN = 36'h0_0002_0000;

  typedef enum logic [3:0] {
    SLD_TGT_DRAM = 4'b0001,
    SLD_TGT_SOUTH = 4'b0010,
    SLD_TGT_PORT = 4'b0100,
    SLD_TGT_ORDINARY = 4'b1000
  } sld_target_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic from_cpu;
    logic smm;
    logic [3:0] byte_en;
    logic [35:0] addr;
  } sld_req_t;

  typedef struct packed {
    logic valid;
    sld_target_t target;
    logic [2:0] port;
    logic [35:0] addr;
  } sld_route_t;

  typedef struct packed {
    logic seg_hit;
    logic compat_hit;
    logic mono_hit;
    logic vga_hit;
    logic apic_south_hit;
    logic apic_port_hit;
    logic [2:0] apic_port;
  } sld_mem_hits_t;

endpackage

// ### sld_io_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sld_io_decode
  import sld_pkg::*;
(
  input wire logic [15:0] addr_i,
  input wire logic [3:0] byte_en_i,
  output logic mono_hit_o,
  output logic mono_only_hit_o,
  output logic vga_hit_o
);

  logic [7:0] dw;
  logic any_be;

  // Upper address bits are not used so every alias matches
  // aliased dword decode
  assign dw = addr_i[9:2];
  assign any_be = |byte_en_i;

  // Decode is per dword, so 3BD-3BF count as monochrome too
  // monochrome port match
  assign mono_only_hit_o = (dw == SLD_DW_MONO_3BC) && any_be;
  assign mono_hit_o = ((dw == SLD_DW_MONO_3B4) && |(byte_en_i & SLD_BE_MONO_3B4)) ||
                      ((dw == SLD_DW_MONO_3B8) && |(byte_en_i & SLD_BE_MONO_3B8)) ||
                      mono_only_hit_o;

  assign vga_hit_o = any_be && (((dw >= SLD_DW_VGA_LO_A) && (dw <= SLD_DW_VGA_HI_A)) ||
                                ((dw >= SLD_DW_VGA_LO_B) && (dw <= SLD_DW_VGA_HI_B)));

endmodule
`default_nettype wire

// ### sld_mem_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sld_mem_decode
  import sld_pkg::*;
(
  input wire logic [35:0] addr_i,
  input wire logic [35:0] top_mem_i,
  input wire logic [1:0] seg_size_i,
  output sld_mem_hits_t hits_o
);

  logic [35:0] seg_len;
  logic [35:0] seg_base;

  assign seg_len = SLD_SEG_LEN_MIN << seg_size_i;
  assign seg_base = top_mem_i - seg_len;

  always_comb begin
    hits_o.seg_hit = (addr_i >= seg_base) && (addr_i < top_mem_i);
    hits_o.compat_hit = (addr_i >= SLD_COMPAT_LO) && (addr_i <= SLD_COMPAT_HI);
    hits_o.mono_hit = (addr_i >= SLD_MONO_MEM_LO) && (addr_i <= SLD_MONO_MEM_HI);
    hits_o.vga_hit = (addr_i >= SLD_VGA_MEM_LO) && (addr_i <= SLD_VGA_MEM_HI);
    hits_o.apic_south_hit = (addr_i >= SLD_APIC_SB_LO) && (addr_i <= SLD_APIC_SB_HI);
    hits_o.apic_port_hit = (addr_i >= SLD_APIC_PORT_LO) && (addr_i <= SLD_APIC_PORT_HI);
    hits_o.apic_port = addr_i[SLD_APIC_WIN_LSB +: 3];
  end

endmodule
`default_nettype wire

// ### sld_legacy_range_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sld_legacy_range_decode
  import sld_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [5:0] legacy_display_enable_i,
  input wire logic [35:0] top_of_low_memory_i,
  input wire sld_req_t req_i,
  output sld_route_t route_o,
  output logic impedance_compensation_disable_o,
  output logic smm_space_lock_o
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic lock;
    logic [7:0] rdata;
    sld_route_t route;
  } sld_state_t;

  sld_state_t state_q;
  sld_state_t state_d;

  logic mono_present;
  logic apic_redirect;
  logic global_smm;
  logic seg_enable;
  logic seg_active;
  logic [1:0] seg_size;

  logic io_mono_hit;
  logic io_mono_only_hit;
  logic io_vga_hit;
  sld_mem_hits_t mem_hits;

  logic [5:0] first_enable;
  logic [5:0] lower_seen;
  logic any_display_enable;
  logic [2:0] display_port;
  logic mono_claimed;

  logic wr_ctrl;
  logic wr_lock;
  logic [7:0] ctrl_write;

  assign mono_present = state_q.ctrl[SLD_BIT_MONO_PRESENT];
  assign apic_redirect = state_q.ctrl[SLD_BIT_APIC_REDIRECT];
  assign global_smm = state_q.ctrl[SLD_BIT_GLOBAL_SMM];
  assign seg_enable = state_q.ctrl[SLD_BIT_SEG_ENABLE];
  assign seg_size = state_q.ctrl[SLD_BIT_SEG_SIZE_HI:SLD_BIT_SEG_SIZE_LO];

  assign seg_active = seg_enable && global_smm;

  sld_io_decode u_io_decode (
    .addr_i(req_i.addr[15:0]),
    .byte_en_i(req_i.byte_en),
    .mono_hit_o(io_mono_hit),
    .mono_only_hit_o(io_mono_only_hit),
    .vga_hit_o(io_vga_hit)
  );

  sld_mem_decode u_mem_decode (
    .addr_i(req_i.addr),
    .top_mem_i(top_of_low_memory_i),
    .seg_size_i(seg_size),
    .hits_o(mem_hits)
  );

  // Lowest-numbered enabled port wins if software enables more than one
  for (genvar p = 0; p < SLD_NUM_PORTS; p++) begin : g_port_pick
    if (p == 0) begin : g_first
      assign lower_seen[p] = 1'b0;
    end else begin : g_rest
      assign lower_seen[p] = lower_seen[p-1] | legacy_display_enable_i[p-1];
    end
    assign first_enable[p] = legacy_display_enable_i[p] & ~lower_seen[p];
  end

  assign any_display_enable = |legacy_display_enable_i;

  always_comb begin
    display_port = 3'h0;
    for (int i = 0; i < SLD_NUM_PORTS; i++) begin
      if (first_enable[i]) begin
        display_port = 3'(i);
      end
    end
  end

  // Monochrome references stay on the south link unless a port owns the
  // display and the present bit does not reclaim them.  An illegal present
  // setting with no enable still lands south, so it cannot misroute.
  // present bit with port enables
  assign mono_claimed = !any_display_enable || mono_present;

  assign wr_ctrl = cfg_wr_i && (cfg_addr_i == SLD_OFS_CTRL);
  assign wr_lock = cfg_wr_i && (cfg_addr_i == SLD_OFS_LOCK);

  assign ctrl_write = state_q.lock ?
                      ((state_q.ctrl & SLD_LOCKED_MASK) | (cfg_wdata_i & ~SLD_LOCKED_MASK)) :
                      cfg_wdata_i;

  always_comb begin
    state_d = state_q;

    // Configuration writes
    if (wr_ctrl) begin
      state_d.ctrl = ctrl_write;
    end
    if (wr_lock && cfg_wdata_i[SLD_BIT_LOCK]) begin
      state_d.lock = 1'b1;
    end

    // Read data held until the next read
    if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        SLD_OFS_CTRL: state_d.rdata = state_q.ctrl;
        SLD_OFS_LOCK: begin
          state_d.rdata = 8'h00;
          state_d.rdata[SLD_BIT_LOCK] = state_q.lock;
        end
        default: state_d.rdata = 8'h00;
      endcase
    end

    // Routing result, one cycle after the request
    state_d.route.valid = req_i.valid;
    state_d.route.addr = req_i.addr;
    state_d.route.port = 3'h0;
    state_d.route.target = SLD_TGT_ORDINARY;

    if (req_i.is_io) begin
      if (io_mono_only_hit) begin
        state_d.route.target = SLD_TGT_SOUTH;
      end else if (io_mono_hit && mono_claimed) begin
        state_d.route.target = SLD_TGT_SOUTH;
      end else if (io_vga_hit || io_mono_hit) begin
        if (any_display_enable) begin
          state_d.route.target = SLD_TGT_PORT;
          state_d.route.port = display_port;
        end else begin
          state_d.route.target = SLD_TGT_SOUTH;
        end
      end
    end else begin
      if (seg_active && mem_hits.seg_hit) begin
        if (req_i.from_cpu && req_i.smm) begin
          state_d.route.target = SLD_TGT_DRAM;
        end else begin
          state_d.route.target = SLD_TGT_SOUTH;
        end
      end else if (global_smm && mem_hits.compat_hit && req_i.from_cpu && req_i.smm) begin
        state_d.route.target = SLD_TGT_DRAM;
      end else if (!apic_redirect && mem_hits.apic_south_hit) begin
        state_d.route.target = SLD_TGT_SOUTH;
      end else if (!apic_redirect && mem_hits.apic_port_hit) begin
        state_d.route.target = SLD_TGT_PORT;
        state_d.route.port = mem_hits.apic_port;
      end else if (mem_hits.mono_hit && mono_claimed) begin
        state_d.route.target = SLD_TGT_SOUTH;
      end else if (mem_hits.vga_hit) begin
        if (any_display_enable) begin
          state_d.route.target = SLD_TGT_PORT;
          state_d.route.port = display_port;
        end else begin
          state_d.route.target = SLD_TGT_SOUTH;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_q.ctrl <= SLD_CTRL_RESET;
      state_q.lock <= 1'b0;
      state_q.rdata <= SLD_RDATA_RESET;
      state_q.route.valid <= 1'b0;
      state_q.route.target <= SLD_TGT_ORDINARY;
      state_q.route.port <= 3'h0;
      state_q.route.addr <= 36'h0_0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign cfg_rdata_o = state_q.rdata;
  assign route_o = state_q.route;
  assign impedance_compensation_disable_o = state_q.ctrl[SLD_BIT_COMP_DISABLE];
  assign smm_space_lock_o = state_q.lock;

endmodule
`default_nettype wire

// ### sld_range_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sld_range_chk
  import sld_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [5:0] legacy_display_enable_i,
  input wire logic [35:0] top_of_low_memory_i,
  input wire sld_req_t req_i,
  input wire sld_route_t route_o,
  input wire logic impedance_compensation_disable_o,
  input wire logic smm_space_lock_o
);
  logic [7:0] ctl_q;
  logic mem;
  logic seg_hit;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the control byte; under lock only bits 6:4 still take writes
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctl_q <= 8'h00;
    end else if (cfg_wr_i && cfg_addr_i == SLD_OFS_CTRL) begin
      ctl_q <= smm_space_lock_o ? (ctl_q & 8'h8F) | (cfg_wdata_i & 8'h70) : cfg_wdata_i;
    end
  end
  assign mem = req_i.valid && !req_i.is_io;
  assign seg_hit = ctl_q[0] && ctl_q[3] && req_i.addr < top_of_low_memory_i &&
                   req_i.addr >= top_of_low_memory_i - (36'h0_0002_0000 << ctl_q[2:1]);
  a_addr_copy:
    assert property (req_i.valid |=> route_o.valid && route_o.addr == $past(req_i.addr)) else $error("route addr");
  a_mono_dword_south:
    assert property (req_i.valid && req_i.is_io && req_i.byte_en != 4'h0 && req_i.addr[9:2] == SLD_DW_MONO_3BC
      |=> route_o.target == SLD_TGT_SOUTH) else $error("3BF not south");
  a_apic_south:
    assert property (mem && !ctl_q[5] && !seg_hit && req_i.addr >= SLD_APIC_SB_LO && req_i.addr <= SLD_APIC_SB_HI
      |=> route_o.target == SLD_TGT_SOUTH) else $error("apic window not south");
  a_apic_port:
    assert property (mem && !ctl_q[5] && !seg_hit && req_i.addr >= SLD_APIC_PORT_LO && req_i.addr <= SLD_APIC_PORT_HI
      |=> route_o.target == SLD_TGT_PORT && route_o.port == $past(req_i.addr[14:12])) else $error("apic port");
  a_seg_guard:
    assert property (mem && seg_hit && !(req_i.from_cpu && req_i.smm) |=> route_o.target == SLD_TGT_SOUTH)
      else $error("segment leak");
  a_seg_admit:
    assert property (mem && seg_hit && req_i.from_cpu && req_i.smm |=> route_o.target == SLD_TGT_DRAM)
      else $error("segment refused");
  a_comp_follow:
    assert property (cfg_wr_i && cfg_addr_i == SLD_OFS_CTRL
      |=> impedance_compensation_disable_o == $past(cfg_wdata_i[4])) else $error("compensation bit");
  a_lock_sticky:
    assert property (smm_space_lock_o |=> smm_space_lock_o) else $error("lock dropped");
  a_ctl_read:
    assert property (cfg_rd_i && cfg_addr_i == SLD_OFS_CTRL |=> cfg_rdata_o == $past(ctl_q)) else $error("ctl read");
endmodule
bind sld_legacy_range_decode sld_range_chk i_sld_range_chk(.core_clk_i, .reset_n_i, .cfg_addr_i, .cfg_wr_i,
  .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o, .legacy_display_enable_i, .top_of_low_memory_i, .req_i, .route_o,
  .impedance_compensation_disable_o, .smm_space_lock_o);
`default_nettype wire

// ### sld_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module sld_cpu_model
  import sld_pkg::*;
(
  input wire logic core_clk_i,
  output sld_req_t req_o
);
  initial req_o = '0;
  // One request held over one edge, then released
  task automatic issue(input logic io, cpu, smm, input logic [3:0] be, input logic [35:0] a);
    req_o = '{1'b1, io, cpu, smm, be, a};
    @(posedge core_clk_i);
    #1;
    // Released bus shows inverted fields so a stale value cannot pass
    req_o = '{1'b0, ~io, ~cpu, ~smm, ~be, ~a};
  endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sld_pkg::*;
  logic clk, rst_n, wr, rd, comp_dis, lock;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] lde;
  logic [35:0] top_mem, lo;
  sld_req_t req;
  sld_route_t route;
  int error_cnt, num_checks;
  sld_legacy_range_decode i_sld_legacy_range_decode(.core_clk_i(clk), .reset_n_i(rst_n), .cfg_addr_i(addr),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .legacy_display_enable_i(lde),
    .top_of_low_memory_i(top_mem), .req_i(req), .route_o(route), .impedance_compensation_disable_o(comp_dis),
    .smm_space_lock_o(lock));
  sld_cpu_model i_sld_cpu_model(.core_clk_i(clk), .req_o(req));
  task automatic check(input logic [35:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle();
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    idle();
    wr = 1'b0;
    idle();
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    addr = a;
    rd = 1'b1;
    idle();
    rd = 1'b0;
    check(rdata, exp);
    idle();
  endtask
  task automatic rt(input logic io, cpu, smm, input logic [3:0] be, input logic [35:0] a,
                    input sld_target_t t, input logic [2:0] p);
    i_sld_cpu_model.issue(io, cpu, smm, be, a);
    check({route.valid, route.target, t == SLD_TGT_PORT ? route.port : 3'h0}, {1'b1, t, p});
    idle();
  endtask
  task automatic io(input logic [15:0] a, input logic [3:0] be, input sld_target_t t, input logic [2:0] p);
    rt(1'b1, 1'b1, 1'b0, be, {20'h0_0000, a}, t, p);
  endtask
  task automatic mem(input logic [35:0] a, input sld_target_t t, input logic [2:0] p);
    rt(1'b0, 1'b1, 1'b0, 4'hF, a, t, p);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rst_n, wr, rd, addr, wdata, lde} = '0;
    top_mem = 36'h0_4000_0000;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_chk(SLD_OFS_CTRL, 8'h00);
    rd_chk(8'h9F, 8'h00);
    io(16'hFFB4, 4'h1, SLD_TGT_SOUTH, 3'd0);
    io(16'h03C0, 4'h1, SLD_TGT_SOUTH, 3'd0);
    mem(36'h0_000B_0000, SLD_TGT_SOUTH, 3'd0);
    lde = 6'h04;
    io(16'h03C0, 4'h1, SLD_TGT_PORT, 3'd2);
    io(16'h03B4, 4'h1, SLD_TGT_PORT, 3'd2);
    io(16'h07BC, 4'h8, SLD_TGT_SOUTH, 3'd0);
    io(16'h03E0, 4'h1, SLD_TGT_ORDINARY, 3'd0);
    io(16'h03DC, 4'h8, SLD_TGT_PORT, 3'd2);
    // Present is only ever set while an enable is on
    wr_reg(SLD_OFS_CTRL, 8'h40);
    io(16'h03B4, 4'hF, SLD_TGT_SOUTH, 3'd0);
    io(16'h03B8, 4'h8, SLD_TGT_PORT, 3'd2);
    io(16'h03C4, 4'h1, SLD_TGT_PORT, 3'd2);
    mem(36'h0_000B_7FFC, SLD_TGT_SOUTH, 3'd0);
    wr_reg(SLD_OFS_CTRL, 8'h10);
    lde = 6'h00;
    check(comp_dis, 1'b1);
    mem(36'h0_FEC7_FFFC, SLD_TGT_SOUTH, 3'd0);
    // The seventh window lies past the port range and carries no port
    for (int i = 0; i < 7; i++) begin
      mem(36'h0_FEC8_0000 + 36'(i) * 36'h0_0000_1000, i < 6 ? SLD_TGT_PORT : SLD_TGT_ORDINARY, 3'(i % 6));
    end
    wr_reg(SLD_OFS_CTRL, 8'h20);
    check(comp_dis, 1'b0);
    mem(36'h0_FEC0_0000, SLD_TGT_ORDINARY, 3'd0);
    wr_reg(SLD_OFS_CTRL, 8'h08);
    rt(1'b0, 1'b1, 1'b1, 4'hF, 36'h0_000A_0000, SLD_TGT_DRAM, 3'd0);
    mem(36'h0_000A_0000, SLD_TGT_SOUTH, 3'd0);
    for (int s = 0; s < 4; s++) begin
      wr_reg(SLD_OFS_CTRL, {5'h01, s[1:0], 1'b1});
      lo = top_mem - (36'h0_0002_0000 << s);
      rt(1'b0, 1'b1, 1'b1, 4'hF, lo, SLD_TGT_DRAM, 3'd0);
      mem(lo, SLD_TGT_SOUTH, 3'd0);
      rt(1'b0, 1'b0, 1'b1, 4'hF, top_mem - 36'h4, SLD_TGT_SOUTH, 3'd0);
      mem(lo - 36'h4, SLD_TGT_ORDINARY, 3'd0);
    end
    wr_reg(SLD_OFS_CTRL, 8'h07);
    rt(1'b0, 1'b1, 1'b1, 4'hF, top_mem - 36'h4, SLD_TGT_ORDINARY, 3'd0);
    wr_reg(SLD_OFS_CTRL, 8'h0F);
    wr_reg(SLD_OFS_LOCK, 8'h10);
    rd_chk(SLD_OFS_LOCK, 8'h10);
    // Present stays clear: no port enable is on at this point
    wr_reg(SLD_OFS_CTRL, 8'hB0);
    rd_chk(SLD_OFS_CTRL, 8'h3F);
    wr_reg(SLD_OFS_LOCK, 8'h00);
    check(lock, 1'b1);
    rst_n = 1'b0;
    idle();
    rst_n = 1'b1;
    check(lock, 1'b0);
    rd_chk(SLD_OFS_CTRL, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
